// ---- hw/ces_conv_ctrl.sv ----
/*
  one converter enable channel: register or pin control with delays.
  assumes pins already synchronised and a step tick from the parent.
*/
`timescale 1ns/10ps
`include "ces_regs.svh"
module ces_conv_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic allowed_in,
  input wire logic step_tick_in,
  input wire logic [2:0] enable_input_pins_in,
  input wire ces_pkg::ces_conv_cfg_t cfg_in,
  output logic conv_on_out
);
  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  // pin chosen by the select field, zero means register control
  wire pin_mode = (cfg_in.pin_select != `CES_SEL_REG); // R10
  wire sel_pin = enable_input_pins_in[cfg_in.pin_select - 2'h1]; // R15
  logic pin_state;
  logic [3:0] steps;
  logic pending;
  wire pin_edge = pin_mode && (sel_pin != pin_state);
  wire [3:0] load_steps = sel_pin ? cfg_in.rise_delay : cfg_in.fall_delay;
  // ------------------------------------------------------------
  // delay timing
  // ------------------------------------------------------------
  // a new edge restarts timing and cancels the old one
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_state <= 1'b0;
      steps <= `CES_DELAY_RST;
      pending <= 1'b0;
    end else if (pin_edge) begin
      pin_state <= sel_pin; // R16
      steps <= load_steps; // R12 R13
      pending <= 1'b1;
    end else if (pending && (steps == 4'h0)) begin
      pending <= 1'b0;
    end else if (pending && step_tick_in) begin
      steps <= steps - 4'h1;
    end
  end
  // output: register bit direct, pin path after its delay
  wire next_on = !allowed_in || !cfg_in.on_bit ? 1'b0 : // R8 R10
                 !pin_mode ? 1'b1 : // R9 R11 R14
                 (pending && steps == 4'h0) ? pin_state : conv_on_out; // R12 R13
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_on_out <= 1'b0;
    end else begin
      conv_on_out <= next_on;
    end
  end
  step_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!allowed_in || !cfg_in.on_bit) |=> !conv_on_out) else $error("converter on while gated"); // R8
  reg_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (allowed_in && cfg_in.on_bit && !pin_mode) |=> conv_on_out) else $error("reg enable ignored"); // R9
  pin_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (pin_edge && load_steps != 4'h0 && cfg_in.on_bit && allowed_in && $stable(cfg_in))
      |=> $stable(conv_on_out)) else $error("pin acted before delay"); // R12
  cancel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pin_edge |=> pin_state == $past(sel_pin) && pending) else $error("edge not retimed"); // R16
endmodule

// ---- hw/ces_pkg.sv ----
/*
  types of the converter enable sequencer.
  assumes ces_regs.svh for numeric constants.
*/
package ces_pkg;
  // device operating modes, gray coded along power-up
  typedef enum logic [1:0] {
    CES_RESET = 2'b00,
    CES_LOAD = 2'b01,
    CES_STANDBY = 2'b11,
    CES_ACTIVE = 2'b10
  } ces_mode_t;
  // per-converter configuration
  typedef struct packed {
    logic on_bit;
    logic [1:0] pin_select;
    logic [3:0] rise_delay;
    logic [3:0] fall_delay;
  } ces_conv_cfg_t;
endpackage

// ---- hw/ces_regs.svh ----
/*
  timing and field constants of the converter enable sequencer.
  assumes a 250 MHz system clock.
*/
`ifndef CES_REGS_SVH
`define CES_REGS_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CES_CLK_MHZ 250
`define CES_HOST_WAIT_US 1200
`define CES_HOST_WAIT_CYC (`CES_HOST_WAIT_US * `CES_CLK_MHZ)
`define CES_DELAY_STEP_US 1000
`define CES_DELAY_STEP_CYC (`CES_DELAY_STEP_US * `CES_CLK_MHZ)
`define CES_OTP_LOAD_CYC 16
`define CES_CLK_LOSS_CYC 64
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define CES_SEL_REG 2'h0
`define CES_NUM_CONV 3
`define CES_DELAY_RST 4'h0
`endif

// ---- hw/ces_sequencer.sv ----
/*
  converter enable sequencer: clock source fallback, power-up order,
  and enable control of two step-down and one step-up converter.
  assumes a 250 MHz clock, host configuration on plain ports, and
  raw pins (reset, enable inputs, external clock present) from outside.
*/
// Behaviour
// R1: with pll enable set in standby or active, run pll and detector and fall back to rc on clock loss.
// R2: with pll and detector on, pulse an interrupt when the external clock goes and when it returns.
// R3: on release of the reset input, load defaults and then open the system interface; the code opens it as the load starts.
// R4: the host waits at least 1.2 ms after reset release before any bus access.
// R5: after defaults load, enter standby and start the watchdog.
// R6: in standby, host changes to settings are accepted.
// R7: outputs and converters are driven by enable pins and by register writes.
// R8: step-down converters may be on only in standby or active.
// R9: a step-down with select 00 follows its register enable bit.
// R10: with enable 1 and select not 00 a step-down follows its pin; enable 0 forces off.
// R11: the step-up follows its bit with select 0, else its pin when its bit is 1.
// R12: under pin control a converter starts its rise delay after the pin rises.
// R13: under pin control a converter stops its fall delay after the pin falls.
// R14: delays apply only under pin control, register writes act at once.
// R15: select values 1, 2, 3 bind to enable inputs 1, 2, 3.
// R16: a pin edge during a pending delay cancels it and times the new edge.
`timescale 1ns/10ps
`include "ces_regs.svh"
module ces_sequencer #(
  parameter int unsigned STEP_CYC = `CES_DELAY_STEP_CYC,
  parameter int unsigned HOST_WAIT_CYC = `CES_HOST_WAIT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic chip_reset_in_n,
  input wire logic [2:0] enable_input_pins_in,
  input wire logic ext_clk_present_in,
  input wire logic pll_enable_in,
  input wire logic go_active_in,
  input wire logic cfg_write_in,
  input wire ces_pkg::ces_conv_cfg_t cfg_data_in,
  input wire logic [1:0] cfg_sel_in,
  input wire logic [1:0] gpo_reg_in,
  input wire logic [1:0] gpo_pin_sel_in,
  output logic [1:0] mode_out,
  output logic sys_if_enable_out,
  output logic host_ready_out,
  output logic watchdog_run_out,
  output logic pll_run_out,
  output logic use_ext_clk_out,
  output logic clk_event_out,
  output logic [2:0] conv_on_out,
  output logic [1:0] general_outputs
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {ext_clk_present_in, chip_reset_in_n, enable_input_pins_in};
      sync_b <= sync_a;
    end
  end
  wire [2:0] pins = sync_b[2:0];
  wire chip_reset_in_n_s = sync_b[3];
  wire ext_s = sync_b[4];
  // ------------------------------------------------------------
  // power-up mode machine
  // ------------------------------------------------------------
  ces_pkg::ces_mode_t mode;
  ces_pkg::ces_mode_t next_mode;
  logic [7:0] load_cnt;
  logic [31:0] wait_cnt;
  wire load_done = (load_cnt == 8'(`CES_OTP_LOAD_CYC - 1));
  wire powered = (mode == ces_pkg::CES_STANDBY) || (mode == ces_pkg::CES_ACTIVE);
  // mode order: reset, load defaults, standby, active
  always_comb begin
    next_mode = mode;
    case (mode)
      ces_pkg::CES_RESET: begin
        if (chip_reset_in_n_s) next_mode = ces_pkg::CES_LOAD; // R3
      end
      ces_pkg::CES_LOAD: begin
        if (load_done) next_mode = ces_pkg::CES_STANDBY; // R5
      end
      ces_pkg::CES_STANDBY: begin
        if (go_active_in) next_mode = ces_pkg::CES_ACTIVE;
      end
      default: begin
        if (!go_active_in) next_mode = ces_pkg::CES_STANDBY;
      end
    endcase
    if (!chip_reset_in_n_s) next_mode = ces_pkg::CES_RESET;
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= ces_pkg::CES_RESET;
      load_cnt <= 8'h00;
      wait_cnt <= 32'h0;
    end else begin
      mode <= next_mode;
      load_cnt <= (mode == ces_pkg::CES_LOAD) ? load_cnt + 8'h01 : 8'h00;
      if (!chip_reset_in_n_s) wait_cnt <= 32'h0;
      else if (wait_cnt < HOST_WAIT_CYC) wait_cnt <= wait_cnt + 32'h1; // R4
    end
  end
  // mode outputs, interface opens as the defaults load starts
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_out <= 2'h0;
      sys_if_enable_out <= 1'b0;
      watchdog_run_out <= 1'b0;
      host_ready_out <= 1'b0;
    end else begin
      mode_out <= next_mode;
      sys_if_enable_out <= (next_mode != ces_pkg::CES_RESET); // R3
      watchdog_run_out <= (next_mode == ces_pkg::CES_STANDBY) ||
                          (next_mode == ces_pkg::CES_ACTIVE); // R5
      host_ready_out <= chip_reset_in_n_s && (wait_cnt >= HOST_WAIT_CYC); // R4
    end
  end
  // ------------------------------------------------------------
  // clock source and detector
  // ------------------------------------------------------------
  logic ext_seen;
  wire pll_on = pll_enable_in && powered; // R1
  wire ext_change = pll_on && (ext_s != ext_seen);
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_seen <= 1'b0;
      pll_run_out <= 1'b0;
      use_ext_clk_out <= 1'b0;
      clk_event_out <= 1'b0;
    end else begin
      ext_seen <= pll_on ? ext_s : 1'b0;
      pll_run_out <= pll_on; // R1
      use_ext_clk_out <= pll_on && ext_s; // R1
      clk_event_out <= ext_change; // R2
    end
  end
  clk_fall_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !pll_on |=> !use_ext_clk_out) else $error("ext clock used without pll"); // R1
  clk_irq_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ext_change |=> clk_event_out) else $error("clock event missed"); // R2
  load_order_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (mode == ces_pkg::CES_RESET && chip_reset_in_n_s) |=> mode == ces_pkg::CES_LOAD)
    else $error("defaults not loaded"); // R3
  // ------------------------------------------------------------
  // configuration store, writable only in standby or active
  // ------------------------------------------------------------
  ces_pkg::ces_conv_cfg_t cfg [`CES_NUM_CONV];
  wire cfg_ok = cfg_write_in && powered && (cfg_sel_in < 2'(`CES_NUM_CONV)); // R6
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `CES_NUM_CONV; i++) cfg[i] <= '0;
    end else if (!chip_reset_in_n_s) begin
      for (int i = 0; i < `CES_NUM_CONV; i++) cfg[i] <= '0;
    end else if (cfg_ok) begin
      cfg[cfg_sel_in] <= cfg_data_in; // R6
    end
  end
  cfg_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cfg_write_in && !powered && chip_reset_in_n_s) |=> $stable(cfg[0])) else $error("write outside standby"); // R6
  // ------------------------------------------------------------
  // delay step tick and converter channels
  // ------------------------------------------------------------
  logic [31:0] step_cnt;
  wire step_tick = (step_cnt == STEP_CYC - 1);
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_cnt <= 32'h0;
    end else begin
      step_cnt <= step_tick ? 32'h0 : step_cnt + 32'h1;
    end
  end
  // channels 0 and 1 step-down, channel 2 step-up
  for (genvar c = 0; c < `CES_NUM_CONV; c++) begin : g_conv
    ces_conv_ctrl u_conv (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .allowed_in(powered), // R8
      .step_tick_in(step_tick),
      .enable_input_pins_in(pins), // R7
      .cfg_in(cfg[c]),
      .conv_on_out(conv_on_out[c])
    );
  end
  // ------------------------------------------------------------
  // general outputs
  // ------------------------------------------------------------
  // register bit, or a pin when its select bit is set
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      general_outputs <= 2'h0;
    end else begin
      general_outputs <= (gpo_pin_sel_in & pins[1:0]) | (~gpo_pin_sel_in & gpo_reg_in); // R7
    end
  end
  gpo_pin_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    gpo_pin_sel_in[0] |=> general_outputs[0] == $past(pins[0])) else $error("gpo pin lost"); // R7
endmodule

// ---- sim/ces_host_model.sv ----
/*
  host model: reset pin, enable pins and configuration writes.
  assumes the bench calls its tasks and the clock runs.
*/
`timescale 1ns/10ps
module ces_host_model (
  input wire logic sys_clk_in,
  input wire logic host_ready_in,
  output logic chip_rst_b_out,
  output logic [2:0] pins_out,
  output logic cfg_write_out,
  output logic [1:0] cfg_sel_out,
  output ces_pkg::ces_conv_cfg_t cfg_data_out
);
  // ------------------------------------------------------------
  // host actions, each launched at a falling edge
  // ------------------------------------------------------------
  // idle: reset pin held, pins pulled low, no write
  initial begin
    chip_rst_b_out = 1'b0;
    pins_out = 3'h0;
    cfg_write_out = 1'b0;
    cfg_sel_out = 2'h3;
    cfg_data_out = '0;
  end
  task automatic set_rst(input logic v);
    @(negedge sys_clk_in);
    chip_rst_b_out = v;
  endtask
  task automatic set_pin(input int idx, input logic v);
    @(negedge sys_clk_in);
    pins_out[idx] = v;
  endtask
  // one-cycle strobe, then the bus shows junk and an ignored channel
  task automatic cfg_wr(input logic [1:0] sel, input ces_pkg::ces_conv_cfg_t d);
    wait (host_ready_in === 1'b1);
    @(negedge sys_clk_in);
    cfg_write_out = 1'b1;
    cfg_sel_out = sel;
    cfg_data_out = d;
    @(negedge sys_clk_in);
    cfg_write_out = 1'b0;
    cfg_sel_out = 2'h3;
    cfg_data_out = ~d;
  endtask
endmodule

// ---- sim/ces_sequencer_bench.sv ----
/*
  self-checking bench of the converter enable sequencer.
  assumes short delay steps and host wait set through parameters.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ces_sequencer_bench;
  localparam int STEP = 4;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ext_clk_present_in = 1'b0;
  logic pll_enable_in = 1'b0;
  logic go_active = 1'b0;
  logic [1:0] gpo_reg = 2'h0, gpo_sel = 2'h0, gpo_out;
  logic chip_rst_b, cfg_write, host_ready_out, pll_run_out, use_ext_clk_out, clk_event_out;
  logic sys_if_enable_out, watchdog_run_out;
  logic [2:0] pins, conv_on_out, conv_prev, exp_q[$];
  logic [1:0] cfg_sel, mode_out;
  ces_pkg::ces_conv_cfg_t cfg_data;
  logic [31:0] seed = 32'h6227;
  logic [3:0] d, fd;
  int n_mismatch = 0, cmp_count = 0, n_event = 0, cyc = 0;
  // ------------------------------------------------------------
  // clock, host, design
  // ------------------------------------------------------------
  always #2 sys_clk_in = ~sys_clk_in;
  ces_host_model host (.sys_clk_in(sys_clk_in), .host_ready_in(host_ready_out),
    .chip_rst_b_out(chip_rst_b), .pins_out(pins), .cfg_write_out(cfg_write),
    .cfg_sel_out(cfg_sel), .cfg_data_out(cfg_data));
  ces_sequencer #(.STEP_CYC(STEP), .HOST_WAIT_CYC(40)) uut (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .chip_reset_in_n(chip_rst_b), .enable_input_pins_in(pins),
    .ext_clk_present_in(ext_clk_present_in), .pll_enable_in(pll_enable_in),
    .go_active_in(go_active), .cfg_write_in(cfg_write), .cfg_data_in(cfg_data),
    .cfg_sel_in(cfg_sel), .gpo_reg_in(gpo_reg), .gpo_pin_sel_in(gpo_sel), .mode_out(mode_out),
    .sys_if_enable_out(sys_if_enable_out), .host_ready_out(host_ready_out),
    .watchdog_run_out(watchdog_run_out), .pll_run_out(pll_run_out),
    .use_ext_clk_out(use_ext_clk_out), .clk_event_out(clk_event_out),
    .conv_on_out(conv_on_out), .general_outputs(gpo_out));
  // each converter change takes the oldest noted expectation
  always @(negedge sys_clk_in) begin
    if (rst_b_in && conv_on_out !== conv_prev) begin
      if (exp_q.size() == 0) `CHK(conv_on_out, conv_prev)
      else `CHK(conv_on_out, exp_q.pop_front())
    end
    conv_prev = conv_on_out;
    if (clk_event_out === 1'b1) n_event++;
  end
  // hang guard
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin n_mismatch++; test_done(); end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bring_up();
    host.set_rst(1'b1);
    for (int i = 0; i < 200 && host_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
    `CHK(mode_out, ces_pkg::CES_STANDBY)
    `CHK({sys_if_enable_out, watchdog_run_out, host_ready_out}, 3'h7)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    `CHK({mode_out, conv_on_out, sys_if_enable_out}, 6'h00)
    bring_up();
    exp_q.push_back(3'h1);
    host.cfg_wr(2'h0, {1'b1, 2'h0, 4'hf, 4'hf});
    repeat (2) @(negedge sys_clk_in);
    `CHK(conv_on_out, 3'h1)
    exp_q.push_back(3'h0);
    host.cfg_wr(2'h0, {1'b0, 2'h0, 4'hf, 4'hf});
    repeat (3) @(negedge sys_clk_in);
    for (int v = 1; v <= 3; v++) begin
      seed = xs(seed);
      d = 4'(seed % 15 + 1);
      fd = 4'((seed >> 8) % 15 + 1);
      host.cfg_wr(2'(v - 1), {1'b1, 2'(v), d, fd});
      exp_q.push_back(3'(1 << (v - 1)));
      host.set_pin(v - 1, 1'b1);
      repeat ((d - 1) * STEP + 2) @(negedge sys_clk_in);
      `CHK(conv_on_out[v - 1], 1'b0)
      repeat (STEP + 8) @(negedge sys_clk_in);
      `CHK(conv_on_out[v - 1], 1'b1)
      exp_q.push_back(3'h0);
      host.set_pin(v - 1, 1'b0);
      repeat ((fd - 1) * STEP + 2) @(negedge sys_clk_in);
      `CHK(conv_on_out[v - 1], 1'b1)
      repeat (STEP + 8) @(negedge sys_clk_in);
      `CHK(conv_on_out[v - 1], 1'b0)
    end
    // park channel 0 under register control so pin 1 drives only channel 1
    host.cfg_wr(2'h0, {1'b0, 2'h0, 4'h0, 4'h0});
    host.cfg_wr(2'h1, {1'b0, 2'h1, 4'h0, 4'h0});
    host.set_pin(0, 1'b1);
    host.cfg_wr(2'h2, {1'b1, 2'h2, 4'h8, 4'h0});
    host.set_pin(1, 1'b1);
    repeat (3) @(negedge sys_clk_in);
    host.set_pin(1, 1'b0);
    repeat (8 * STEP + 12) @(negedge sys_clk_in);
    `CHK(conv_on_out, 3'h0)
    exp_q.push_back(3'h1);
    host.cfg_wr(2'h0, {1'b1, 2'h0, 4'h0, 4'h0});
    exp_q.push_back(3'h0);
    host.set_rst(1'b0);
    repeat (20) @(negedge sys_clk_in);
    `CHK({mode_out, conv_on_out}, 5'h00)
    bring_up();
    pll_enable_in = 1'b1;
    ext_clk_present_in = 1'b1;
    repeat (100) @(negedge sys_clk_in);
    `CHK({pll_run_out, use_ext_clk_out}, 2'h3)
    ext_clk_present_in = 1'b0;
    repeat (100) @(negedge sys_clk_in);
    `CHK(use_ext_clk_out, 1'b0)
    `CHK(n_event, 2)
    // active mode still lets a register enable act
    go_active = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    `CHK(mode_out, ces_pkg::CES_ACTIVE)
    exp_q.push_back(3'h2);
    host.cfg_wr(2'h1, {1'b1, 2'h0, 4'h0, 4'h0});
    repeat (3) @(negedge sys_clk_in);
    `CHK(conv_on_out, 3'h2)
    // general outputs: bit 0 copies pin 1, bit 1 from its register bit
    gpo_sel = 2'h1;
    gpo_reg = 2'h2;
    host.set_pin(0, 1'b0);
    repeat (5) @(negedge sys_clk_in);
    `CHK(gpo_out, 2'h2)
    host.set_pin(0, 1'b1);
    repeat (5) @(negedge sys_clk_in);
    `CHK(gpo_out, 2'h3)
    test_done();
  end
endmodule
